// [rtl/sfr_pkg.sv]
/*
  Constants for the serial flash read, identification and deep sleep logic.
  Assumes a 100 MHz system clock that oversamples the serial link.
*/
package sfr_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int SLEEP_ENTRY_TIME_NS = 3000;
  localparam int WAKE_RECOVERY_TIME_NS = 3000;
  // Entry is a longest time, so it rounds down; recovery is a least time.
  localparam logic [15:0] SLEEP_ENTRY_CYC = 16'((SLEEP_ENTRY_TIME_NS / CLK_PERIOD_NS < 1) ?
    1 : SLEEP_ENTRY_TIME_NS / CLK_PERIOD_NS);
  localparam logic [15:0] WAKE_RECOVERY_CYC =
    16'((WAKE_RECOVERY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // Edges between a select pin rise and the timer load; the entry budget pays for them.
  localparam logic [15:0] SYNC_LAT_CYC = 16'h0003;

  // ----------------------------------------------------------------
  // Instruction codes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_FAST_READ = 8'h0B;
  localparam logic [7:0] OP_DUAL_READ = 8'h3B;
  localparam logic [7:0] OP_MAKER_DEV_ID = 8'h90;
  localparam logic [7:0] OP_STD_ID = 8'h9F;
  localparam logic [7:0] OP_UNIQUE_ID = 8'h4B;
  localparam logic [7:0] OP_SLEEP = 8'hB9;
  localparam logic [7:0] OP_WAKE = 8'hAB;

  // ----------------------------------------------------------------
  // Field sizes and phase lengths (last bit index of each phase)
  // ----------------------------------------------------------------
  localparam int MEM_AW = 21;
  localparam int ADDR_W = 24;
  localparam logic [5:0] OPC_LAST = 6'h07;
  localparam logic [5:0] ADDR_LAST = 6'h17;
  localparam logic [5:0] DUMMY8_LAST = 6'h07;
  localparam logic [5:0] DUMMY24_LAST = 6'h17;
  localparam logic [5:0] DUMMY32_LAST = 6'h1F;
  localparam logic [2:0] SINGLE_LAST = 3'h7;
  localparam logic [2:0] DUAL_LAST = 3'h3;
  localparam logic [23:0] STD_ID_LAST = 24'h000002;

  // ----------------------------------------------------------------
  // Identification values; all of them are arbitrary.
  // ----------------------------------------------------------------
  localparam logic [7:0] MAKER_CODE = 8'h5A;
  localparam logic [7:0] DEVICE_CODE = 8'h3C;
  localparam logic [7:0] MEM_TYPE_CODE = 8'h42;
  localparam logic [7:0] CAPACITY_CODE = 8'h17;
  localparam logic [63:0] UNIQUE_NUMBER = 64'h0123_4567_89AB_CDEF;

  // ----------------------------------------------------------------
  // Command phase states
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_OPC = 6'h02,
    ST_ADDR = 6'h04,
    ST_DUMMY = 6'h08,
    ST_DATA = 6'h10,
    ST_IGNORE = 6'h20
  } sfr_state_t;

endpackage

// [rtl/sfr_core.sv]
/*
  Serial flash command engine for reads, identification and deep sleep.
  Assumes the serial clock, select and data pins are asynchronous and are
  oversampled by i_clk at well over four times the link rate; the memory
  array is filled through the load port, and the write cycle engine
  reports its activity on i_write_cycle_active.
*/
// Behaviour
// [RL1] Read takes 24-bit address, MSB first, rising edges
// [RL2] Read data changes on falling clock edges
// [RL3] Address steps by one after each byte
// [RL4] Select high ends read and releases output
// [RL5] Read ignored while write cycle busy
// [RL6] Fast read adds one dummy byte
// [RL7] Dual read drives two bits per clock
// [RL8] Odd bits on high line, even low
// [RL9] Maker/device ID: address zero, maker first
// [RL10] Address one returns device code first
// [RL11] Standard ID: maker, type, capacity bytes
// [RL12] Standard ID not decoded while busy
// [RL13] Host avoids standard ID during sleep
// [RL14] Select high returns to standby anytime
// [RL15] Unique ID: four dummies, 64-bit number
// [RL16] Sleep only if select rises at bit eight
// [RL17] Sleep entered within entry time
// [RL18] Asleep, only wake opcode is recognised
// [RL19] Power-up always in normal operation
// [RL20] No commands during wake recovery time
// [RL21] Busy flag high during write cycle
// [RL22] Stream wraps past top address to zero
`timescale 1ns/1ps
module sfr_core (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_sclk,
  input wire logic i_cs_b,
  input wire logic i_dual_line_low,
  input wire logic i_dual_line_high,
  output logic o_dual_line_low,
  output logic o_dual_line_low_oe,
  output logic o_dual_line_high,
  output logic o_dual_line_high_oe,
  input wire logic i_write_cycle_active,
  input wire logic i_load_en,
  input wire logic [sfr_pkg::MEM_AW-1:0] i_load_addr,
  input wire logic [7:0] i_load_data,
  output logic o_deep_sleep_state,
  output logic o_cycle_busy_flag
);
  import sfr_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    sfr_state_t st;
    logic sclk_m;
    logic sclk_s;
    logic sclk_p;
    logic cs_m;
    logic cs_s;
    logic si_m;
    logic si_s;
    logic [7:0] sh_in;
    logic [5:0] bcnt;
    logic [5:0] need;
    logic [7:0] op;
    logic [ADDR_W-1:0] addr;
    logic [7:0] out_sr;
    logic [2:0] obit;
    logic sleep;
    logic dpd_arm;
    logic wake_arm;
    logic [15:0] ent_cnt;
    logic [15:0] rec_cnt;
    logic busy;
    logic lo;
    logic lo_oe;
    logic hi;
    logic hi_oe;
  } sfr_core_t;

  sfr_core_t q;
  sfr_core_t d;
  logic rise;
  logic fall;
  logic opc_done;
  logic last_bit;
  logic [7:0] in_byte;
  logic [7:0] mem [0:(1 << MEM_AW) - 1];

  // The high line is only ever driven by this end in these commands.
  logic unused_high_in;
  assign unused_high_in = i_dual_line_high;

  always_ff @(posedge i_clk) begin
    if (i_load_en) begin
      mem[i_load_addr] <= i_load_data;
    end
  end

  // ----------------------------------------------------------------
  // Byte sources
  // ----------------------------------------------------------------
  function automatic logic [7:0] pick(input logic [7:0] op, input logic [ADDR_W-1:0] a);
    logic [7:0] b;
    b = mem[a[MEM_AW-1:0]];
    if (op == OP_MAKER_DEV_ID) begin
      b = a[0] ? DEVICE_CODE : MAKER_CODE; // [RL9] [RL10]
    end else if (op == OP_STD_ID) begin
      b = (a[1:0] == 2'h0) ? MAKER_CODE : (a[1:0] == 2'h1) ? MEM_TYPE_CODE : CAPACITY_CODE; // [RL11]
    end else if (op == OP_UNIQUE_ID) begin
      b = UNIQUE_NUMBER[8'(63 - 8 * int'(a[2:0])) -: 8]; // [RL15]
    end else if (op == OP_WAKE) begin
      b = DEVICE_CODE;
    end
    return b;
  endfunction

  function automatic logic [ADDR_W-1:0] step(input logic [7:0] op, input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] n;
    n = {3'h0, a[MEM_AW-1:0] + 21'h000001}; // [RL3] [RL22]
    if (op == OP_STD_ID && a == STD_ID_LAST) begin
      n = '0;
    end
    return n;
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    opc_done = 1'b0;
    last_bit = 1'b0;
    d.sclk_m = i_sclk;
    d.sclk_s = q.sclk_m;
    d.sclk_p = q.sclk_s;
    d.cs_m = i_cs_b;
    d.cs_s = q.cs_m;
    d.si_m = i_dual_line_low;
    d.si_s = q.si_m;
    d.busy = i_write_cycle_active; // [RL21]
    rise = q.sclk_s & ~q.sclk_p;
    fall = ~q.sclk_s & q.sclk_p;
    in_byte = {q.sh_in[6:0], q.si_s};
    if (q.ent_cnt != 16'h0000) begin
      d.ent_cnt = q.ent_cnt - 16'h0001;
      if (q.ent_cnt == 16'h0001) begin
        d.sleep = 1'b1; // [RL17]
      end
    end
    if (q.rec_cnt != 16'h0000) begin
      d.rec_cnt = q.rec_cnt - 16'h0001;
    end
    if (q.cs_s) begin
      d.st = ST_IDLE; // [RL14]
      d.lo_oe = 1'b0; // [RL4]
      d.hi_oe = 1'b0;
      d.dpd_arm = 1'b0;
      d.wake_arm = 1'b0;
      if (q.dpd_arm) begin
        d.ent_cnt = SLEEP_ENTRY_CYC - SYNC_LAT_CYC; // [RL16] [RL17]
      end
      if (q.wake_arm) begin
        d.sleep = 1'b0;
        d.ent_cnt = 16'h0000;
        d.rec_cnt = WAKE_RECOVERY_CYC; // [RL20]
      end
    end else if (q.st == ST_IDLE) begin
      d.st = ST_OPC;
      d.bcnt = 6'h00;
    end else if (rise) begin
      d.sh_in = in_byte;
      d.bcnt = q.bcnt + 6'h01;
      d.dpd_arm = 1'b0; // [RL16]
      unique case (q.st)
        ST_OPC: begin
          if (q.bcnt == OPC_LAST) begin
            opc_done = 1'b1;
            d.op = in_byte;
            d.bcnt = 6'h00;
            d.addr = '0;
            d.obit = 3'h0;
            d.st = ST_IGNORE;
            if (q.rec_cnt != 16'h0000) begin
              d.st = ST_IGNORE; // [RL20]
            end else if (q.sleep) begin
              d.wake_arm = (in_byte == OP_WAKE); // [RL18]
            end else if (in_byte == OP_SLEEP) begin
              d.dpd_arm = 1'b1; // [RL16]
            end else if (q.busy) begin
              d.st = ST_IGNORE; // [RL5] [RL12]
            end else if (in_byte == OP_READ || in_byte == OP_FAST_READ ||
                         in_byte == OP_DUAL_READ || in_byte == OP_MAKER_DEV_ID) begin
              d.st = ST_ADDR; // [RL1] [RL9]
            end else if (in_byte == OP_STD_ID) begin
              d.st = ST_DATA;
              d.out_sr = pick(OP_STD_ID, '0); // [RL11]
            end else if (in_byte == OP_UNIQUE_ID) begin
              d.st = ST_DUMMY;
              d.need = DUMMY32_LAST; // [RL15]
            end else if (in_byte == OP_WAKE) begin
              d.st = ST_DUMMY;
              d.need = DUMMY24_LAST;
            end
          end
        end
        ST_ADDR: begin
          d.addr = {q.addr[ADDR_W-2:0], q.si_s}; // [RL1]
          if (q.bcnt == ADDR_LAST) begin
            d.bcnt = 6'h00;
            if (q.op == OP_FAST_READ || q.op == OP_DUAL_READ) begin
              d.st = ST_DUMMY;
              d.need = DUMMY8_LAST; // [RL6]
            end else begin
              d.st = ST_DATA;
              d.out_sr = pick(q.op, d.addr);
            end
          end
        end
        ST_DUMMY: begin
          if (q.bcnt == q.need) begin
            d.st = ST_DATA;
            d.out_sr = pick(q.op, q.addr);
          end
        end
        ST_IDLE, ST_DATA, ST_IGNORE: begin
        end
      endcase
    end else if (fall && q.st == ST_DATA) begin
      d.hi = q.out_sr[7]; // [RL2]
      d.hi_oe = 1'b1;
      if (q.op == OP_DUAL_READ) begin
        d.lo = q.out_sr[6]; // [RL7] [RL8]
        d.lo_oe = 1'b1;
        d.out_sr = {q.out_sr[5:0], 2'b00};
        last_bit = (q.obit == DUAL_LAST);
      end else begin
        d.out_sr = {q.out_sr[6:0], 1'b0};
        last_bit = (q.obit == SINGLE_LAST);
      end
      d.obit = last_bit ? 3'h0 : q.obit + 3'h1;
      if (last_bit) begin
        d.addr = step(q.op, q.addr); // [RL3]
        d.out_sr = pick(q.op, d.addr);
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      q <= '0;
      q.st <= ST_IDLE;
      q.cs_m <= 1'b1;
      q.cs_s <= 1'b1;
      q.sleep <= 1'b0; // [RL19]
    end else begin
      q <= d;
    end
  end

  assign o_dual_line_low = q.lo;
  assign o_dual_line_low_oe = q.lo_oe;
  assign o_dual_line_high = q.hi;
  assign o_dual_line_high_oe = q.hi_oe;
  assign o_deep_sleep_state = q.sleep;
  assign o_cycle_busy_flag = q.busy;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  localparam int CHK_ENTRY_MAX = int'(SLEEP_ENTRY_CYC) - 2;

  default clocking chk_cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_b);

  sequence seq_opc_done;
    !q.cs_s && q.st == ST_OPC && rise && q.bcnt == OPC_LAST;
  endsequence

  sequence seq_sleep_armed;
    q.cs_s && q.dpd_arm && !q.wake_arm;
  endsequence

  sequence seq_data_fall;
    !q.cs_s && q.st == ST_DATA && fall;
  endsequence

  chk_select_release: assert property ( // [RL4] [RL14]
    q.cs_s |=> !o_dual_line_low_oe && !o_dual_line_high_oe && q.st == ST_IDLE)
    else $error("Output still driven after select released.");

  chk_read_to_addr: assert property ( // [RL1]
    seq_opc_done ##0 (in_byte == OP_READ && !q.busy && !q.sleep && q.rec_cnt == 16'h0000)
    |=> q.st == ST_ADDR)
    else $error("Read opcode did not enter address phase.");

  chk_busy_reject: assert property ( // [RL5] [RL12]
    seq_opc_done ##0 (q.busy && in_byte != OP_SLEEP) |=> q.st == ST_IGNORE)
    else $error("Command accepted while write cycle busy.");

  chk_sleep_ignore: assert property ( // [RL18]
    seq_opc_done ##0 (q.sleep && in_byte != OP_WAKE) |=> q.st == ST_IGNORE && !q.wake_arm)
    else $error("Command recognised during deep sleep.");

  chk_sleep_entry: assert property ( // [RL17]
    seq_sleep_armed |-> ##[1:CHK_ENTRY_MAX] q.sleep)
    else $error("Deep sleep not entered within entry time.");

  chk_wake_quiet: assert property ( // [RL20]
    seq_opc_done ##0 (q.rec_cnt != 16'h0000) |=> q.st == ST_IGNORE)
    else $error("Command accepted during wake recovery.");

  chk_dual_lines: assert property ( // [RL7] [RL8]
    seq_data_fall ##0 (q.op == OP_DUAL_READ)
    |=> o_dual_line_high == $past(q.out_sr[7]) && o_dual_line_low == $past(q.out_sr[6])
        && o_dual_line_low_oe && o_dual_line_high_oe)
    else $error("Dual output bits misplaced.");

  chk_single_line: assert property ( // [RL2]
    seq_data_fall ##0 (q.op != OP_DUAL_READ)
    |=> o_dual_line_high == $past(q.out_sr[7]) && o_dual_line_high_oe && !o_dual_line_low_oe)
    else $error("Single output bit wrong.");

  chk_addr_step: assert property ( // [RL3] [RL22]
    seq_data_fall ##0 (q.op == OP_READ && last_bit)
    |=> q.addr[MEM_AW-1:0] == $past(q.addr[MEM_AW-1:0]) + 21'h000001
        && q.addr[ADDR_W-1:MEM_AW] == 3'h0)
    else $error("Read address did not step by one.");

  chk_sleep_discard: assert property ( // [RL16]
    (!q.cs_s && q.dpd_arm && rise) |=> !q.dpd_arm)
    else $error("Deep sleep kept armed after extra clock.");

endmodule

// [test/sfr_host_model.sv]
/*
  Host side of the serial link: frames, clocks and samples a command.
  Assumes the bench resolves both data lines and feeds the levels back.
*/
`timescale 1ns/1ps
module sfr_host_model (
  input wire logic i_low,
  input wire logic i_high,
  output logic o_sclk,
  output logic o_cs_b,
  output logic o_mosi,
  output logic o_mosi_oe,
  output logic o_rx_valid,
  output logic [7:0] o_rx_byte
);
  localparam realtime HALF = 62.5;
  initial begin
    o_sclk = 1'b0;
    o_cs_b = 1'b1;
    o_mosi = 1'b0;
    o_mosi_oe = 1'b0;
    o_rx_valid = 1'b0;
    o_rx_byte = 8'h00;
  end
  // ----------------------------------------------------------------
  // Framing
  // ----------------------------------------------------------------
  // The serial clock stays low outside frames, so no stray edge is seen.
  task automatic start();
    o_cs_b = 1'b0;
    o_mosi_oe = 1'b1;
    #(HALF);
  endtask
  task automatic stop();
    #(HALF);
    o_cs_b = 1'b1;
    o_mosi_oe = 1'b0;
    #100;
  endtask
  // Top n bits of b, most significant first, set up before each rise.
  task automatic send_bits(input logic [7:0] b, input int n);
    for (int i = 7; i > 7 - n; i--) begin
      o_mosi = b[i];
      #(HALF);
      o_sclk = 1'b1;
      #(HALF);
      o_sclk = 1'b0;
    end
  endtask
  // Samples on the rise; the device moved its lines after the last fall.
  task automatic recv_byte(input bit dual);
    logic [7:0] r;
    r = 8'h00;
    o_mosi_oe = ~dual;
    repeat (dual ? 4 : 8) begin
      #(HALF);
      o_sclk = 1'b1;
      r = dual ? {r[5:0], i_high, i_low} : {r[6:0], i_high};
      #(HALF);
      o_sclk = 1'b0;
    end
    o_rx_byte = r;
    o_rx_valid = 1'b1;
    #1;
    o_rx_valid = 1'b0;
  endtask
endmodule

// [test/tb_top.sv]
/*
  Self-checking bench for the serial flash command engine.
  Assumes the host model file is compiled first and a 100 MHz system clock.
*/
`timescale 1ns/1ps
module tb_top;
  import sfr_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic busy = 1'b0;
  logic load_en = 1'b0;
  logic [MEM_AW-1:0] load_addr = '0;
  logic [7:0] load_data = 8'h00;
  logic tgl = 1'b0;
  logic drv_seen = 1'b0;
  logic sclk, cs_b, mosi, mosi_oe, rx_v, low_o, low_oe, high_o, high_oe, sleep, busy_flag;
  logic low_w, high_w;
  logic [7:0] rx_b;
  logic [7:0] mem [logic [MEM_AW-1:0]];
  logic [7:0] exp_q[$];
  logic [31:0] seed = 32'd65;
  int mismatches = 0;
  int checks = 0;
  int n;
  always #5 clk = ~clk;
  // A released line shows a changing level, never its last driven value.
  always @(posedge clk) tgl <= ~tgl;
  always @(posedge clk) if (low_oe | high_oe) drv_seen <= 1'b1;
  assign low_w = low_oe ? low_o : (mosi_oe ? mosi : tgl);
  assign high_w = high_oe ? high_o : ~tgl;
  sfr_core dut (.i_clk(clk), .i_rst_b(rst_b), .i_sclk(sclk), .i_cs_b(cs_b),
    .i_dual_line_low(low_w), .i_dual_line_high(high_w), .o_dual_line_low(low_o),
    .o_dual_line_low_oe(low_oe), .o_dual_line_high(high_o), .o_dual_line_high_oe(high_oe),
    .i_write_cycle_active(busy), .i_load_en(load_en), .i_load_addr(load_addr),
    .i_load_data(load_data), .o_deep_sleep_state(sleep), .o_cycle_busy_flag(busy_flag));
  sfr_host_model host (.i_low(low_w), .i_high(high_w), .o_sclk(sclk), .o_cs_b(cs_b),
    .o_mosi(mosi), .o_mosi_oe(mosi_oe), .o_rx_valid(rx_v), .o_rx_byte(rx_b));
  // ----------------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t %s: seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("mismatches=%0d checks=%0d", mismatches, checks);
    if (mismatches == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge rx_v) begin
    check(rx_b, (exp_q.size() != 0) ? exp_q.pop_front() : ~rx_b, "read byte");
  end
  initial begin
    #900us;
    mismatches++;
    $display("[ERR] %0t watchdog expired", $time);
    end_sim();
  end
  // ----------------------------------------------------------------
  // Stimulus helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic load(input logic [MEM_AW-1:0] a);
    seed = xs(seed);
    mem[a] = seed[7:0];
    @(posedge clk);
    load_en <= 1'b1;
    load_addr <= a;
    load_data <= seed[7:0];
    @(posedge clk);
    load_en <= 1'b0;
  endtask
  task automatic frame(input logic [7:0] op, input logic [23:0] a, input int na,
      input int nd, input int nr, input bit dual);
    host.start();
    host.send_bits(op, 8);
    for (int i = na - 1; i >= 0; i--) host.send_bits(a[8*i +: 8], 8);
    repeat (nd) host.send_bits(8'h00, 8);
    repeat (nr) host.recv_byte(dual);
    host.stop();
    check({6'h0, low_oe, high_oe}, 8'h00, "drive after select high");
  endtask
  task automatic wait_clk(input int c);
    repeat (c) @(posedge clk);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    wait_clk(5);
    rst_b <= 1'b1;
    wait_clk(3);
    check({6'h0, sleep, busy_flag}, 8'h00, "state after reset");
    load(21'h1FFFFE);
    load(21'h1FFFFF);
    for (int i = 0; i < 20; i++) load(MEM_AW'(i));
    for (int i = 0; i < 4; i++) exp_q.push_back(mem[MEM_AW'(21'h1FFFFE + i)]);
    frame(OP_READ, 24'h1FFFFE, 3, 0, 4, 0);
    for (int i = 0; i < 3; i++) exp_q.push_back(mem[MEM_AW'(16 + i)]);
    frame(OP_FAST_READ, 24'h000010, 3, 1, 3, 0);
    for (int i = 0; i < 3; i++) exp_q.push_back(mem[MEM_AW'(5 + i)]);
    frame(OP_DUAL_READ, 24'h000005, 3, 1, 3, 1);
    exp_q = {exp_q, MAKER_CODE, DEVICE_CODE, MAKER_CODE};
    frame(OP_MAKER_DEV_ID, 24'h000000, 3, 0, 3, 0);
    exp_q = {exp_q, DEVICE_CODE, MAKER_CODE};
    frame(OP_MAKER_DEV_ID, 24'h000001, 3, 0, 2, 0);
    host.start();
    host.send_bits(OP_STD_ID, 8);
    host.send_bits(8'h00, 3);
    host.stop();
    exp_q = {exp_q, MAKER_CODE, MEM_TYPE_CODE, CAPACITY_CODE};
    frame(OP_STD_ID, 24'h0, 0, 0, 3, 0);
    for (int i = 7; i >= 0; i--) exp_q.push_back(UNIQUE_NUMBER[8*i +: 8]);
    frame(OP_UNIQUE_ID, 24'h0, 0, 4, 8, 0);
    wait_clk(1);
    busy <= 1'b1;
    wait_clk(3);
    check({7'h0, busy_flag}, 8'h01, "busy flag set");
    drv_seen = 1'b0;
    frame(OP_READ, 24'h000010, 3, 2, 0, 0);
    check({7'h0, drv_seen}, 8'h00, "read while busy");
    frame(OP_STD_ID, 24'h0, 0, 3, 0, 0);
    check({7'h0, drv_seen}, 8'h00, "standard id while busy");
    wait_clk(1);
    busy <= 1'b0;
    wait_clk(3);
    check({7'h0, busy_flag}, 8'h00, "busy flag clear");
    host.start();
    host.send_bits(OP_SLEEP, 8);
    host.send_bits(8'h00, 1);
    host.stop();
    wait_clk(320);
    check({7'h0, sleep}, 8'h00, "sleep without byte boundary");
    frame(OP_SLEEP, 24'h0, 0, 0, 0, 0);
    n = 0;
    while (!sleep && n < 400) begin
      @(posedge clk);
      n++;
    end
    // The count starts ten cycles after the select rise, so the budget shrinks to match.
    check({7'h0, sleep & (n <= 291)}, 8'h01, "sleep entry time");
    drv_seen = 1'b0;
    frame(OP_READ, 24'h000010, 3, 2, 0, 0);
    check({6'h0, drv_seen, sleep}, 8'h01, "read while asleep");
    frame(OP_WAKE, 24'h0, 0, 0, 0, 0);
    check({7'h0, sleep}, 8'h00, "wake recognised");
    frame(OP_STD_ID, 24'h0, 0, 3, 0, 0);
    check({7'h0, drv_seen}, 8'h00, "command during recovery");
    wait_clk(300);
    exp_q.push_back(MAKER_CODE);
    frame(OP_STD_ID, 24'h0, 0, 0, 1, 0);
    check(8'(exp_q.size()), 8'h00, "all bytes returned");
    end_sim();
  end
endmodule
